// >>> core/hpc_pin_mux.sv
// Host port pin multiplexer with general purpose I/O fallback.
`timescale 1ns/1ps
module hpc_pin_mux (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       ce,
  input  wire logic [hpc_pkg::CTRL_W-1:0] port_ctrl,
  input  wire logic [hpc_pkg::PINS-1:0]   data_dir,
  input  wire logic [hpc_pkg::PINS-1:0]   gpio_out,
  input  wire logic                       stop_mode,
  input  wire logic [hpc_pkg::DATA_W-1:0] rd_data,
  input  wire logic                       request,
  input  wire logic                       transmit_request,
  input  wire logic                       receive_request,
  input  wire logic [hpc_pkg::PINS-1:0]   pin_in,
  output logic      [hpc_pkg::PINS-1:0]   pin_out,
  output logic      [hpc_pkg::PINS-1:0]   pin_oe_n,
  output logic      [hpc_pkg::PINS-1:0]   gpio_in,
  output logic      [hpc_pkg::ADDR_W-1:0] host_addr,
  output logic      [hpc_pkg::DATA_W-1:0] host_wr_data,
  output logic                            host_select,
  output logic                            host_read,
  output logic                            host_write,
  output logic                            addr_strobe,
  output logic                            acknowledge
);
  import hpc_pkg::*;

  // ---------------------------------------------------------------
  // Configuration decode
  // ---------------------------------------------------------------
  logic            host_function;
  logic            mux_bus;
  logic            dbl_strobe;
  logic            dbl_req;
  logic            req_open;
  logic [PINS-1:0] pin_s;
  hpc_role_t       role;

  assign host_function = port_ctrl[CTRL_HOST_FUNCTION];
  assign mux_bus       = port_ctrl[CTRL_MUX_BUS];
  assign dbl_strobe    = port_ctrl[CTRL_DOUBLE_STROBE];
  assign dbl_req       = port_ctrl[CTRL_DOUBLE_REQ];
  assign req_open      = port_ctrl[CTRL_REQ_OPEN];

  always_comb begin
    case ({stop_mode, host_function, mux_bus})
      3'b000, 3'b001: role = HPC_GPIO;
      3'b010:         role = HPC_PLAIN;
      3'b011:         role = HPC_MUXED;
      default:        role = HPC_STOPPED;
    endcase
  end

  hpc_sync u_sync (
    .clk (clk),
    .rst (rst),
    .ce  (ce),
    .d   (pin_in),
    .q   (pin_s)
  );

  // ---------------------------------------------------------------
  // Host strobe decode
  // ---------------------------------------------------------------
  logic as_act;
  logic cs_act;
  logic ds_act;
  logic rd_act;
  logic wr_act;
  logic ack_act;
  logic sel;
  logic rd_acc;
  logic wr_acc;
  logic host_on;

  assign host_on = (role == HPC_PLAIN) || (role == HPC_MUXED);
  // A low polarity bit means the pin is active low.
  assign as_act  = pin_s[PIN_ADDR0] ~^ port_ctrl[CTRL_AS_POL];
  assign cs_act  = pin_s[PIN_CS] ~^ port_ctrl[CTRL_CS_POL];
  assign ds_act  = pin_s[PIN_DS] ~^ port_ctrl[CTRL_DS_POL];
  assign rd_act  = pin_s[PIN_RW] ~^ port_ctrl[CTRL_DS_POL];
  assign wr_act  = pin_s[PIN_DS] ~^ port_ctrl[CTRL_DS_POL];
  assign ack_act = pin_s[PIN_ACK] ~^ port_ctrl[CTRL_ACK_POL];
  assign sel     = (role == HPC_MUXED) || (role == HPC_PLAIN && cs_act);

  always_comb begin
    if (dbl_strobe) begin
      rd_acc = sel && rd_act;
      wr_acc = sel && wr_act && !rd_act;
    end else begin
      rd_acc = sel && ds_act && pin_s[PIN_RW];
      wr_acc = sel && ds_act && !pin_s[PIN_RW];
    end
  end

  // ---------------------------------------------------------------
  // Host side registered outputs
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] addr_lo_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      addr_lo_q <= DATA_ZERO;
    end else if (ce && role == HPC_MUXED && as_act) begin
      addr_lo_q <= pin_s[PIN_DATA_MSB:PIN_DATA_LSB];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      host_addr <= ADDR_ZERO;
    end else if (ce && role == HPC_MUXED) begin
      host_addr <= {pin_s[PIN_CS], pin_s[PIN_ADDR2], pin_s[PIN_ADDR1],
                    addr_lo_q};
    end else if (ce && role == HPC_PLAIN) begin
      host_addr <= {NMUX_PAD, DATA_ZERO[2:0], pin_s[PIN_ADDR2],
                    pin_s[PIN_ADDR1], pin_s[PIN_ADDR0]};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      host_wr_data <= DATA_ZERO;
    end else if (ce && host_on && wr_acc) begin
      host_wr_data <= pin_s[PIN_DATA_MSB:PIN_DATA_LSB];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      host_select <= 1'b0;
      host_read   <= 1'b0;
      host_write  <= 1'b0;
      addr_strobe <= 1'b0;
      acknowledge <= 1'b0;
    end else if (ce && role != HPC_STOPPED) begin
      host_select <= host_on && sel;
      host_read   <= host_on && rd_acc;
      host_write  <= host_on && wr_acc;
      addr_strobe <= role == HPC_MUXED && as_act;
      acknowledge <= host_on && !dbl_req && ack_act;
    end
  end

  // ---------------------------------------------------------------
  // General purpose inputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      gpio_in <= PINS_ZERO;
    end else if (ce && role == HPC_GPIO) begin
      gpio_in <= pin_s;
    end
  end

  // ---------------------------------------------------------------
  // Pin drivers
  // ---------------------------------------------------------------
  logic            req_lvl;
  logic            trq_lvl;
  logic            rrq_lvl;
  logic            req_pol;
  logic [PINS-1:0] drv_o;
  logic [PINS-1:0] drv_oe_n;

  assign req_pol = port_ctrl[CTRL_REQ_POL];
  assign req_lvl = request ~^ req_pol;
  assign trq_lvl = transmit_request ~^ req_pol;
  assign rrq_lvl = receive_request ~^ req_pol;

  genvar g;
  generate
    for (g = 0; g < PINS; g++) begin : g_pin
      always_comb begin
        drv_o[g]    = gpio_out[g];
        drv_oe_n[g] = !data_dir[g];
        if (host_on) begin
          drv_o[g]    = 1'b0;
          drv_oe_n[g] = 1'b1;
          if (g <= PIN_DATA_MSB) begin
            drv_o[g]    = rd_data[g % DATA_W];
            drv_oe_n[g] = !rd_acc;
          end
        end
      end
    end
  endgenerate

  logic [PINS-1:0] nxt_o;
  logic [PINS-1:0] nxt_oe_n;

  always_comb begin
    nxt_o    = drv_o;
    nxt_oe_n = drv_oe_n;
    if (host_on) begin
      if (dbl_req) begin
        nxt_o[PIN_REQ] = trq_lvl;
        nxt_o[PIN_ACK] = rrq_lvl;
        nxt_oe_n[PIN_ACK] = 1'b0;
      end else begin
        nxt_o[PIN_REQ] = req_lvl;
      end
      nxt_oe_n[PIN_REQ] = 1'b0;
      if (req_open) begin
        // Open drain pulls low only; the high level is left to the pull-up.
        nxt_oe_n[PIN_REQ] = nxt_o[PIN_REQ];
        nxt_o[PIN_REQ]    = 1'b0;
        if (dbl_req) begin
          nxt_oe_n[PIN_ACK] = nxt_o[PIN_ACK];
          nxt_o[PIN_ACK]    = 1'b0;
        end
      end
    end
    if (role == HPC_STOPPED) begin
      nxt_o    = pin_out;
      nxt_oe_n = PINS_OFF;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_out  <= PINS_ZERO;
      pin_oe_n <= PINS_OFF;
    end else if (ce) begin
      pin_out  <= nxt_o;
      pin_oe_n <= nxt_oe_n;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_read_seen;
    ce && host_on && rd_acc;
  endsequence

  sequence s_data_driven;
    pin_oe_n[PIN_DATA_LSB] == 1'b0 && pin_out[PIN_DATA_MSB:PIN_DATA_LSB]
      == $past(rd_data);
  endsequence

  a_host_read_drive: assert property (@(posedge clk) disable iff (rst)
    s_read_seen |=> s_data_driven)
    else $error("Data lines not driven on host read.");

  a_data_float: assert property (@(posedge clk) disable iff (rst)
    ce && host_on && !rd_acc |=> pin_oe_n[PIN_DATA_MSB:PIN_DATA_LSB]
      == PINS_OFF[DATA_W-1:0])
    else $error("Data lines driven outside a host read.");

  a_gpio_dir: assert property (@(posedge clk) disable iff (rst)
    ce && role == HPC_GPIO |=> pin_oe_n == ~$past(data_dir)
      && pin_out == $past(gpio_out))
    else $error("GPIO direction does not follow data direction.");

  a_stop_float: assert property (@(posedge clk) disable iff (rst)
    ce && stop_mode |=> pin_oe_n == PINS_OFF && $stable(gpio_in))
    else $error("Stop state left a pin driven or input live.");

  a_req_level: assert property (@(posedge clk) disable iff (rst)
    ce && host_on && !dbl_req && !req_open |=> !pin_oe_n[PIN_REQ]
      && pin_out[PIN_REQ] == ($past(request) ~^ $past(req_pol)))
    else $error("Request pin level wrong.");

  a_rrq_level: assert property (@(posedge clk) disable iff (rst)
    ce && host_on && dbl_req && !req_open |=> !pin_oe_n[PIN_ACK]
      && pin_out[PIN_ACK] == ($past(receive_request) ~^ $past(req_pol)))
    else $error("Receive request pin level wrong.");

  a_open_drain: assert property (@(posedge clk) disable iff (rst)
    ce && host_on && req_open |=> pin_out[PIN_REQ] == 1'b0)
    else $error("Open drain request drove a high level.");

  a_plain_addr: assert property (@(posedge clk) disable iff (rst)
    ce && role == HPC_PLAIN |=> host_addr[2:0]
      == $past(pin_s[PIN_ADDR2:PIN_ADDR0]) && host_addr[ADDR_W-1:3] == 8'h00)
    else $error("Plain bus address lines wrong.");

  a_cs_gate: assert property (@(posedge clk) disable iff (rst)
    ce && role == HPC_PLAIN && !cs_act |=> !host_select && !host_read)
    else $error("Access seen without chip select.");

  a_sgl_write: assert property (@(posedge clk) disable iff (rst)
    ce && host_on && !dbl_strobe && sel && ds_act && !pin_s[PIN_RW]
      |=> host_write && !host_read)
    else $error("Single strobe write not decoded.");
endmodule

// >>> pkg/hpc_pkg.sv
// Constants for the host port pin multiplexer.
package hpc_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int PINS   = 16;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 11;
  localparam int CTRL_W = 16;

  // ---------------------------------------------------------------
  // Port control fields
  // ---------------------------------------------------------------
  localparam int CTRL_HOST_FUNCTION = 0;
  localparam int CTRL_MUX_BUS       = 1;
  localparam int CTRL_DOUBLE_STROBE = 2;
  localparam int CTRL_DOUBLE_REQ    = 3;
  localparam int CTRL_REQ_OPEN      = 4;
  localparam int CTRL_AS_POL        = 5;
  localparam int CTRL_CS_POL        = 6;
  localparam int CTRL_DS_POL        = 7;
  localparam int CTRL_REQ_POL       = 8;
  localparam int CTRL_ACK_POL       = 9;

  // ---------------------------------------------------------------
  // Pin positions
  // ---------------------------------------------------------------
  localparam int PIN_DATA_LSB = 0;
  localparam int PIN_DATA_MSB = 7;
  localparam int PIN_ADDR0    = 8;
  localparam int PIN_ADDR1    = 9;
  localparam int PIN_ADDR2    = 10;
  localparam int PIN_RW       = 11;
  localparam int PIN_DS       = 12;
  localparam int PIN_CS       = 13;
  localparam int PIN_REQ      = 14;
  localparam int PIN_ACK      = 15;

  // ---------------------------------------------------------------
  // Reset values and address padding
  // ---------------------------------------------------------------
  localparam logic [PINS-1:0]   PINS_OFF  = 16'hFFFF;
  localparam logic [PINS-1:0]   PINS_ZERO = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 11'h000;
  localparam logic [4:0]        NMUX_PAD  = 5'h00;

  // ---------------------------------------------------------------
  // Port roles
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    HPC_GPIO    = 2'b00,
    HPC_PLAIN   = 2'b01,
    HPC_MUXED   = 2'b11,
    HPC_STOPPED = 2'b10
  } hpc_role_t;

endpackage

// >>> core/hpc_sync.sv
// Two-stage synchroniser for the port pins.
`timescale 1ns/1ps
module hpc_sync (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     ce,
  input  wire logic [hpc_pkg::PINS-1:0] d,
  output logic      [hpc_pkg::PINS-1:0] q
);
  import hpc_pkg::*;

  logic [PINS-1:0] meta_q;

  // ---------------------------------------------------------------
  // Synchroniser stages
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= PINS_ZERO;
      q      <= PINS_ZERO;
    end else if (ce) begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

// >>> sim/hpc_host_model.sv
// Host bus model that resolves every port pin from both parties.
`timescale 1ns/1ps
module hpc_host_model (
  input  wire logic                     clk,
  input  wire logic [hpc_pkg::PINS-1:0] dev_out,
  input  wire logic [hpc_pkg::PINS-1:0] dev_oe_n,
  input  wire logic [hpc_pkg::PINS-1:0] host_val,
  input  wire logic [hpc_pkg::PINS-1:0] host_en,
  output logic      [hpc_pkg::PINS-1:0] pin_lvl
);
  import hpc_pkg::*;
  logic [PINS-1:0] float_q = PINS_ZERO;
  // ---------------------------------------------------------------
  // Undriven pins
  // ---------------------------------------------------------------
  // Nobody drives these pins, so their level flips every cycle.
  always @(posedge clk) begin
    float_q <= ~float_q;
  end
  // ---------------------------------------------------------------
  // Wire level
  // ---------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      if (!dev_oe_n[i]) pin_lvl[i] = dev_out[i];
      else if (host_en[i]) pin_lvl[i] = host_val[i];
      else pin_lvl[i] = float_q[i];
    end
  end
endmodule

// >>> sim/host_port_pin_config_tb.sv
// Self-checking testbench for the host port pin multiplexer.
`timescale 1ns/1ps
module host_port_pin_config_tb;
  import hpc_pkg::*;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, stop_mode = 1'b0;
  logic [CTRL_W-1:0] port_ctrl = 16'h0000;
  logic [PINS-1:0]   data_dir = 16'h0000, gpio_out = 16'h0000;
  logic [PINS-1:0]   host_val = 16'h0000, host_en = 16'h0000;
  logic [DATA_W-1:0] rd_data = 8'h3C;
  logic request = 1'b0, transmit_request = 1'b0, receive_request = 1'b0;
  logic [PINS-1:0]   pin_lvl, pin_out, pin_oe_n, gpio_in;
  logic [ADDR_W-1:0] host_addr;
  logic [DATA_W-1:0] host_wr_data;
  logic host_select, host_read, host_write, addr_strobe, acknowledge;
  logic [4:0]        st;
  int n_mismatch = 0;
  int samples_checked = 0;
  assign st = {host_select, host_read, host_write, addr_strobe, acknowledge};
  always #5 clk = ~clk;
  hpc_pin_mux uut (.clk(clk), .rst(rst), .ce(ce), .port_ctrl(port_ctrl),
    .data_dir(data_dir), .gpio_out(gpio_out), .stop_mode(stop_mode),
    .rd_data(rd_data), .request(request),
    .transmit_request(transmit_request), .receive_request(receive_request),
    .pin_in(pin_lvl), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .gpio_in(gpio_in), .host_addr(host_addr), .host_wr_data(host_wr_data),
    .host_select(host_select), .host_read(host_read),
    .host_write(host_write), .addr_strobe(addr_strobe),
    .acknowledge(acknowledge));
  hpc_host_model host (.clk(clk), .dev_out(pin_out), .dev_oe_n(pin_oe_n),
    .host_val(host_val), .host_en(host_en), .pin_lvl(pin_lvl));
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic report_and_stop();
    if (n_mismatch == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Applies a setting and pin pattern, then waits out bus turnaround.
  task automatic setp(input logic [15:0] c, input logic [15:0] v,
                      input logic [15:0] e);
    @(posedge clk);
    port_ctrl <= c;
    host_val <= v;
    host_en <= e;
    repeat (7) @(posedge clk);
    #1;
  endtask
  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk(pin_oe_n, 16'hFFFF);
    chk(pin_out, 16'h0000);
    chk({host_addr, st}, 16'h0000);
    @(posedge clk);
    data_dir <= 16'h00FF;
    gpio_out <= 16'h00A5;
    setp(16'h0000, 16'h5A00, 16'hFF00);
    chk(pin_oe_n, 16'hFF00);
    chk(pin_out & 16'h00FF, 16'h00A5);
    chk(gpio_in & 16'hFF00, 16'h5A00);
    @(posedge clk);
    stop_mode <= 1'b1;
    setp(16'h0000, 16'hA500, 16'hFF00);
    chk(pin_oe_n, 16'hFFFF);
    chk(gpio_in & 16'hFF00, 16'h5A00);
    @(posedge clk);
    stop_mode <= 1'b0;
    setp(16'h0001, 16'h8D00, 16'hBF00);
    chk(st, 5'h18);
    chk(host_addr, 11'h005);
    chk({pin_oe_n[7:0], pin_out[7:0]}, 16'h003C);
    setp(16'h0001, 16'hAD00, 16'hBF00);
    chk(st, 5'h00);
    chk(pin_oe_n & 16'h00FF, 16'h00FF);
    setp(16'h0001, 16'h8596, 16'hBFFF);
    chk(st, 5'h14);
    chk({pin_oe_n[7:0], host_wr_data}, 16'hFF96);
    setp(16'h00C1, 16'hBD00, 16'hBF00);
    chk(st, 5'h18);
    setp(16'h0005, 16'h9500, 16'hBF00);
    chk(st, 5'h18);
    setp(16'h0005, 16'h8D5A, 16'hBFFF);
    chk({st, 3'h0, host_wr_data}, {5'h14, 3'h0, 8'h5A});
    setp(16'h0003, 16'hBA7E, 16'hBFFF);
    chk(st, 5'h12);
    chk(host_addr, 11'h57E);
    setp(16'h0003, 16'hAB00, 16'hBF00);
    chk(host_addr, 11'h57E);
    chk({st, 3'h0, pin_out[7:0]}, {5'h18, 3'h0, 8'h3C});
    @(posedge clk);
    request <= 1'b1;
    setp(16'h0001, 16'h8000, 16'h8000);
    chk({pin_out[14], pin_oe_n[15:14]}, 16'h0002);
    setp(16'h0101, 16'h8000, 16'h8000);
    chk({pin_out[14], pin_oe_n[15:14]}, 16'h0006);
    setp(16'h0011, 16'h8000, 16'h8000);
    chk({pin_out[14], pin_oe_n[15:14]}, 16'h0002);
    @(posedge clk);
    request <= 1'b0;
    setp(16'h0011, 16'h8000, 16'h8000);
    chk({pin_out[14], pin_oe_n[15:14]}, 16'h0003);
    setp(16'h0001, 16'h8000, 16'h8000);
    chk({pin_out[14], pin_oe_n[15:14]}, 16'h0006);
    @(posedge clk);
    transmit_request <= 1'b1;
    setp(16'h0009, 16'h0000, 16'h0000);
    chk({pin_out[15:14], pin_oe_n[15:14]}, 16'h0008);
    @(posedge clk);
    transmit_request <= 1'b0;
    receive_request <= 1'b1;
    setp(16'h0009, 16'h0000, 16'h0000);
    chk({pin_out[15:14], pin_oe_n[15:14]}, 16'h0004);
    setp(16'h0001, 16'h0000, 16'h8000);
    chk(acknowledge, 16'h0001);
    setp(16'h0201, 16'h0000, 16'h8000);
    chk(acknowledge, 16'h0000);
    setp(16'h0201, 16'h8000, 16'h8000);
    chk(acknowledge, 16'h0001);
    @(posedge clk);
    ce <= 1'b0;
    setp(16'h0201, 16'h0000, 16'h8000);
    chk(acknowledge, 16'h0001);
    @(posedge clk);
    ce <= 1'b1;
    setp(16'h0201, 16'h0000, 16'h8000);
    chk(acknowledge, 16'h0000);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk(pin_oe_n, 16'hFFFF);
    chk({host_addr, st}, 16'h0000);
    report_and_stop();
  end
  initial begin
    #100000;
    n_mismatch++;
    report_and_stop();
  end
endmodule
